// >>> csp_pkg.sv
package csp_pkg;

    // Register byte offsets on the Avalon-MM slave.
    localparam logic [3:0] OFS_RC_TRIM      = 4'h0;
    localparam logic [3:0] OFS_PRESCALE     = 4'h4;
    localparam logic [3:0] OFS_ASYNC_TIMER  = 4'h8;
    localparam logic [3:0] OFS_STATUS       = 4'hC;

    // Field positions.
    localparam int PS_UNLOCK_BIT   = 7;
    localparam int PS_SEL_MSB      = 3;
    localparam int AT_EXT_CLK_BIT  = 0;

    // Clock-source fuse codes.
    localparam logic [3:0] SRC_LF_1K   = 4'h6;
    localparam logic [3:0] SRC_LF_32K  = 4'h7;
    localparam logic [3:0] SRC_RC      = 4'h2;
    localparam logic [3:0] SRC_EXT     = 4'h0;

    // Start-up fuse codes.
    localparam logic [1:0] SUT_14CK    = 2'h0;
    localparam logic [1:0] SUT_4MS     = 2'h1;
    localparam logic [1:0] SUT_65MS    = 2'h2;

    // Prescale select values.
    localparam logic [3:0] PS_DIV1     = 4'h0;
    localparam logic [3:0] PS_DIV8     = 4'h3;
    localparam logic [3:0] PS_MAX      = 4'h8;
    localparam logic [7:0] PS_UNLOCK_WORD = 8'h80;

    // Timing counts in source clocks and watchdog oscillator cycles.
    localparam logic [16:0] RESET_CK        = 17'h0000E;
    localparam logic [16:0] WAKE_SHORT_CK   = 17'h00006;
    localparam logic [16:0] WAKE_1K_CK      = 17'h00400;
    localparam logic [16:0] WDT_4K_CYC      = 17'h01000;
    localparam logic [2:0]  UNLOCK_WINDOW   = 3'h4;

    // Trim value 8'h00, not used: reset always loads calib_byte into the trim register.
    localparam logic [7:0] TRIM_RESET       = 8'h00;

    typedef enum logic [1:0] {
        CSP_SRC_EXT = 2'h0,
        CSP_SRC_RC  = 2'h1,
        CSP_SRC_LF  = 2'h2,
        CSP_SRC_RSV = 2'h3
    } csp_src_type;

    typedef enum logic [4:0] {
        CSP_ST_RESET_CK = 5'b00001,
        CSP_ST_RESET_WD = 5'b00010,
        CSP_ST_RUN      = 5'b00100,
        CSP_ST_SLEEP    = 5'b01000,
        CSP_ST_WAKE     = 5'b10000
    } csp_state_type;

    // Classifies the clock-source fuse field.
    function automatic csp_src_type csp_src_class(input logic [3:0] code);
        csp_src_type r;
        r = CSP_SRC_RSV;
        if (code == SRC_LF_1K || code == SRC_LF_32K) begin
            r = CSP_SRC_LF;
        end else if (code == SRC_RC) begin
            r = CSP_SRC_RC;
        end else if (code == SRC_EXT) begin
            r = CSP_SRC_EXT;
        end
        return r;
    endfunction

    // Terminal count of the prescaler for a select code: factor minus one.
    function automatic logic [7:0] csp_div_mask(input logic [3:0] sel);
        logic [8:0] f;
        f = 9'h001 << sel;
        return 8'(f - 9'h001);
    endfunction

endpackage

// >>> csp_div_if.sv
`timescale 1ns/10ps
`default_nettype none
interface csp_div_if;
    logic [3:0] sel_req;
    logic [3:0] sel_cur;
    logic       tick;
    logic       clk_hi;

    modport ctrl (
        output sel_req,
        input  sel_cur,
        input  tick,
        input  clk_hi
    );

    modport div (
        input  sel_req,
        output sel_cur,
        output tick,
        output clk_hi
    );
endinterface
`default_nettype wire

// >>> csp_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
module csp_prescaler (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic div8_at_reset,
    csp_div_if.div    dv
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [3:0] sel_q;
    logic [3:0] sel_d;
    logic       hi_q;
    logic       hi_d;
    logic [7:0] mask;
    logic       last;

    always_comb begin
        mask  = csp_pkg::csp_div_mask(sel_q);
        last  = (cnt_q == mask);
        sel_d = sel_q;
        cnt_d = last ? 8'h00 : 8'(cnt_q + 8'h01); // RULE_17
        // A new factor is taken only at the end of the running period.
        if (last) begin
            sel_d = dv.sel_req; // RULE_16 RULE_18
        end
        hi_d = (cnt_d <= (csp_pkg::csp_div_mask(sel_d) >> 1));
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cnt_q <= 8'h00;
            sel_q <= div8_at_reset ? csp_pkg::PS_DIV8 : csp_pkg::PS_DIV1; // RULE_19
            hi_q  <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            sel_q <= sel_d;
            hi_q  <= hi_d;
        end
    end

    assign dv.sel_cur = sel_q;
    assign dv.tick    = rst_n & last; // RULE_15
    assign dv.clk_hi  = hi_q;
endmodule
`default_nettype wire

// >>> csp_clock_ctrl.sv
// Functional notes
// RULE_01: Fuse codes 0110/0111 select low-frequency crystal.
// RULE_02: Crystal reset delay: 14CK, +4.1ms, +65ms, reserved.
// RULE_03: Crystal wake-up waits 1K or 32K clocks.
// RULE_04: Fuse code 0010 selects internal RC oscillator.
// RULE_05: Reset loads calibration byte into trim register.
// RULE_06: Reset time-out runs on watchdog oscillator ticks.
// RULE_07: RC wake-up 6 clocks; reset delay by start-up fuses.
// RULE_08: Fuse code 0000 selects external clock input.
// RULE_09: External clock wake-up 6 clocks; same reset delays.
// RULE_10: External clock changes under 2% per cycle.
// RULE_11: Clock-out fuse drives system clock, even in reset.
// RULE_12: Clock-out pin carries the divided system clock.
// RULE_13: Timer oscillator allowed only with RC source.
// RULE_14: Timer external-clock bit accepts clock on pin.
// RULE_15: Prescaler divides all synchronous clock domains.
// RULE_16: Division change produces no clock glitch.
// RULE_17: Prescaler counts undivided clock, state unreadable.
// RULE_18: New factor active after old plus new period.
// RULE_19: Divide-by-eight fuse starts clock divided by eight.
// RULE_20: Reset select is 0000, or 0011 with fuse.
// RULE_21: Select 0000 to 1000 gives factors 1 to 256.
// RULE_22: Unlock write, then new value within four cycles.
// RULE_23: Fuse values sampled at reset, static afterwards.
`timescale 1ns/10ps
`default_nettype none
module csp_clock_ctrl #(
    parameter logic [16:0] WAKE_32K_CK = 17'h08000,
    parameter logic [16:0] WDT_64K_CYC = 17'h10000
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [3:0]  clock_source_fuses,
    input  wire logic [1:0]  startup_time_fuses,
    input  wire logic        clock_out_fuse,
    input  wire logic        divide_by_eight_fuse,
    input  wire logic [7:0]  calib_byte,
    input  wire logic        wdt_osc_tick,
    input  wire logic        sleep_req,
    input  wire logic        wake_req,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output logic [1:0]       clock_source,
    output logic             cpu_run,
    output logic             sys_clk_tick,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe,
    output logic             crystal_in_used,
    output logic             timer_osc_enable,
    output logic             timer_ext_clock_select,
    output logic [7:0]       rc_trim_value
);
    csp_div_if dv ();

    csp_prescaler csp_prescaler_i (
        .ref_clk       (ref_clk),
        .rst_n         (rst_n),
        .div8_at_reset (divide_by_eight_fuse),
        .dv            (dv.div)
    );

    // Fuse copies, refreshed only while reset is held.
    logic [3:0]              src_fuse_q;
    logic [1:0]              sut_fuse_q;
    logic                    cko_fuse_q;
    logic [3:0]              src_fuse_d;
    logic [1:0]              sut_fuse_d;
    logic                    cko_fuse_d;
    csp_pkg::csp_src_type    src_class;

    always_comb begin
        src_fuse_d = src_fuse_q;
        sut_fuse_d = sut_fuse_q;
        cko_fuse_d = cko_fuse_q;
        if (!rst_n) begin
            src_fuse_d = clock_source_fuses; // RULE_23
            sut_fuse_d = startup_time_fuses;
            cko_fuse_d = clock_out_fuse;
        end
    end

    always_ff @(posedge ref_clk) begin
        src_fuse_q <= src_fuse_d;
        sut_fuse_q <= sut_fuse_d;
        cko_fuse_q <= cko_fuse_d;
    end

    assign src_class = csp_pkg::csp_src_class(src_fuse_q); // RULE_01 RULE_04 RULE_08

    // Start-up sequencer.
    csp_pkg::csp_state_type state_q;
    csp_pkg::csp_state_type state_d;
    logic [16:0]            tmr_q;
    logic [16:0]            tmr_d;
    logic [16:0]            wdt_len;
    logic [16:0]            wake_len;

    always_comb begin
        case (sut_fuse_q)
            csp_pkg::SUT_4MS:  wdt_len = csp_pkg::WDT_4K_CYC; // RULE_02 RULE_07 RULE_09
            csp_pkg::SUT_65MS: wdt_len = WDT_64K_CYC;
            default:           wdt_len = 17'h00000;
        endcase
        if (src_class == csp_pkg::CSP_SRC_LF) begin
            wake_len = (src_fuse_q == csp_pkg::SRC_LF_32K) ? WAKE_32K_CK : csp_pkg::WAKE_1K_CK; // RULE_03
        end else begin
            wake_len = csp_pkg::WAKE_SHORT_CK; // RULE_07 RULE_09
        end
    end

    always_comb begin
        state_d = state_q;
        tmr_d   = tmr_q;
        case (state_q)
            csp_pkg::CSP_ST_RESET_CK: begin
                tmr_d = 17'(tmr_q + 17'h00001);
                if (tmr_d >= csp_pkg::RESET_CK) begin
                    tmr_d   = 17'h00000;
                    state_d = (wdt_len == 17'h00000) ? csp_pkg::CSP_ST_RUN : csp_pkg::CSP_ST_RESET_WD;
                end
            end
            csp_pkg::CSP_ST_RESET_WD: begin
                if (wdt_osc_tick) begin
                    tmr_d = 17'(tmr_q + 17'h00001); // RULE_06
                end
                if (tmr_d >= wdt_len) begin
                    tmr_d   = 17'h00000;
                    state_d = csp_pkg::CSP_ST_RUN;
                end
            end
            csp_pkg::CSP_ST_RUN: begin
                if (sleep_req) begin
                    state_d = csp_pkg::CSP_ST_SLEEP;
                end
            end
            csp_pkg::CSP_ST_SLEEP: begin
                if (wake_req) begin
                    tmr_d   = 17'h00000;
                    state_d = csp_pkg::CSP_ST_WAKE;
                end
            end
            csp_pkg::CSP_ST_WAKE: begin
                tmr_d = 17'(tmr_q + 17'h00001);
                if (tmr_d >= wake_len) begin
                    tmr_d   = 17'h00000;
                    state_d = csp_pkg::CSP_ST_RUN;
                end
            end
            default: begin
                tmr_d   = 17'h00000;
                state_d = csp_pkg::CSP_ST_RESET_CK;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= csp_pkg::CSP_ST_RESET_CK;
            tmr_q   <= 17'h00000;
        end else begin
            state_q <= state_d;
            tmr_q   <= tmr_d;
        end
    end

    // Register file.
    logic [7:0]  trim_q;
    logic [7:0]  trim_d;
    logic [3:0]  ps_sel_q;
    logic [3:0]  ps_sel_d;
    logic [2:0]  unlock_cnt_q;
    logic [2:0]  unlock_cnt_d;
    logic        ext_clk_q;
    logic        ext_clk_d;
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        bus_req;
    logic        wr_take;
    logic [7:0]  wbyte;
    logic        rd_take;
    logic [3:0]  wr_hit;
    logic [3:0]  rd_hit;
    logic [14:0] status_word;

    // One-hot register select: bit 0 trim, bit 1 prescale, bit 2 timer, bit 3 status.
    function automatic logic [3:0] reg_hit(input logic [3:0] addr);
        logic [3:0] h;
        h = 4'h0;
        case (addr)
            csp_pkg::OFS_RC_TRIM:     h = 4'h1;
            csp_pkg::OFS_PRESCALE:    h = 4'h2;
            csp_pkg::OFS_ASYNC_TIMER: h = 4'h4;
            csp_pkg::OFS_STATUS:      h = 4'h8;
            default:                  h = 4'h0;
        endcase
        return h;
    endfunction

    assign bus_req = avs_read | avs_write;
    assign wr_take = avs_write & ~ack_q & avs_byteenable[0];
    assign rd_take = avs_read & ~ack_q;
    assign wbyte   = avs_writedata[7:0];
    assign wr_hit  = wr_take ? reg_hit(avs_address) : 4'h0;
    assign rd_hit  = rd_take ? reg_hit(avs_address) : 4'h0;

    // Status word, from bit 0 up: clock fuse code, source class, active select, one-hot state.
    assign status_word = {state_q, dv.sel_cur, src_class, src_fuse_q};

    always_comb begin
        trim_d = trim_q;
        if (wr_hit[0]) begin
            trim_d = wbyte;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            trim_q <= calib_byte; // RULE_05
        end else begin
            trim_q <= trim_d;
        end
    end

    // Prescale select and its unlock window.
    always_comb begin
        ps_sel_d     = ps_sel_q;
        unlock_cnt_d = unlock_cnt_q;
        if (unlock_cnt_q != 3'h0) begin
            unlock_cnt_d = 3'(unlock_cnt_q - 3'h1); // RULE_22
        end
        if (wr_hit[1]) begin
            if (wbyte == csp_pkg::PS_UNLOCK_WORD) begin
                // A repeated unlock neither extends nor ends the window.
                if (unlock_cnt_q == 3'h0) begin
                    unlock_cnt_d = csp_pkg::UNLOCK_WINDOW; // RULE_22
                end
            end else if (!wbyte[csp_pkg::PS_UNLOCK_BIT] && unlock_cnt_q != 3'h0) begin
                if (wbyte[csp_pkg::PS_SEL_MSB:0] <= csp_pkg::PS_MAX) begin
                    ps_sel_d = wbyte[csp_pkg::PS_SEL_MSB:0]; // RULE_21
                end
                unlock_cnt_d = 3'h0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ps_sel_q     <= divide_by_eight_fuse ? csp_pkg::PS_DIV8 : csp_pkg::PS_DIV1; // RULE_20
            unlock_cnt_q <= 3'h0;
        end else begin
            ps_sel_q     <= ps_sel_d;
            unlock_cnt_q <= unlock_cnt_d;
        end
    end

    always_comb begin
        ext_clk_d = ext_clk_q;
        if (wr_hit[2]) begin
            ext_clk_d = wbyte[csp_pkg::AT_EXT_CLK_BIT]; // RULE_14
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ext_clk_q <= 1'b0;
        end else begin
            ext_clk_q <= ext_clk_d;
        end
    end

    // Every request is answered in its second cycle; read data are loaded at the first edge.
    always_comb begin
        ack_d   = bus_req & ~ack_q;
        rdata_d = rdata_q;
        if (rd_take) begin
            rdata_d = 32'h00000000;
        end
        case (rd_hit)
            4'h1:    rdata_d = {24'h000000, trim_q};
            4'h2:    rdata_d = {24'h000000, (unlock_cnt_q != 3'h0), 3'h0, ps_sel_q};
            4'h4:    rdata_d = {31'h00000000, ext_clk_q};
            4'h8:    rdata_d = {17'h00000, status_word};
            default: ;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            ack_q   <= ack_d;
            rdata_q <= rdata_d;
        end
    end

    assign dv.sel_req      = ps_sel_q; // RULE_15
    assign avs_waitrequest = bus_req & ~ack_q;
    assign avs_readdata    = rdata_q;

    // Pin and clock outputs.
    logic run_q;
    logic run_d;
    logic tosc_q;
    logic tosc_d;

    // Run follows the next state so that it rises with the first running cycle.
    always_comb begin
        run_d  = (state_d == csp_pkg::CSP_ST_RUN);
        tosc_d = (src_class == csp_pkg::CSP_SRC_RC); // RULE_13
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            run_q  <= 1'b0;
            tosc_q <= 1'b0;
        end else begin
            run_q  <= run_d;
            tosc_q <= tosc_d;
        end
    end

    assign clock_source           = src_class;
    assign cpu_run                = run_q;
    assign sys_clk_tick           = dv.tick & run_q;
    assign crystal_in_used        = (src_class != csp_pkg::CSP_SRC_RC);
    assign timer_osc_enable       = tosc_q; // RULE_13
    assign timer_ext_clock_select = ext_clk_q & tosc_q; // RULE_14
    assign rc_trim_value          = trim_q;

    // Undivided source is shown in reset, the divided clock afterwards.
    assign clock_out_pin_oe = rst_n ? cko_fuse_q : clock_out_fuse; // RULE_11
    assign clock_out_pin_o  = (!rst_n || dv.sel_cur == csp_pkg::PS_DIV1) ? ref_clk : dv.clk_hi; // RULE_11 RULE_12
endmodule
`default_nettype wire

// >>> csp_clock_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module csp_clock_ctrl_checker (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic       clock_out_fuse,
    input wire logic [7:0] calib_byte,
    input wire logic       avs_read,
    input wire logic       avs_write,
    input wire logic       avs_waitrequest,
    input wire logic [1:0] clock_source,
    input wire logic       cpu_run,
    input wire logic       sys_clk_tick,
    input wire logic       clock_out_pin_oe,
    input wire logic       crystal_in_used,
    input wire logic       timer_osc_enable,
    input wire logic       timer_ext_clock_select,
    input wire logic [7:0] rc_trim_value
);
    default clocking cb @(posedge ref_clk);
    endclocking
    sequence s_release;
        !rst_n ##1 rst_n;
    endsequence
    sequence s_held_13;
        !cpu_run [*8] ##1 !cpu_run [*5];
    endsequence
    a_startup_held: assert property (s_release |-> s_held_13) else $error("cpu ran early");
    a_trim_calib: assert property (!rst_n |=> rc_trim_value == $past(calib_byte)) else $error("trim not loaded");
    a_oe_reset: assert property (!rst_n |-> clock_out_pin_oe == clock_out_fuse) else $error("clock out off");
    a_oe_static: assert property (disable iff (!rst_n) $stable(clock_out_pin_oe)) else $error("oe moved");
    a_source_static: assert property (disable iff (!rst_n) $stable(clock_source)) else $error("source moved");
    a_timer_osc_rc: assert property (disable iff (!rst_n) timer_osc_enable |-> clock_source == 2'h1)
        else $error("timer osc without rc");
    a_ext_gated: assert property (timer_ext_clock_select |-> timer_osc_enable) else $error("ext clock ungated");
    a_xtal_used: assert property (crystal_in_used == (clock_source != 2'h1)) else $error("crystal pin use");
    a_tick_run: assert property (sys_clk_tick |-> cpu_run) else $error("tick while stopped");
    a_one_wait: assert property (disable iff (!rst_n) (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus stalled");
endmodule
bind csp_clock_ctrl csp_clock_ctrl_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .clock_out_fuse(clock_out_fuse),
    .calib_byte(calib_byte), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .clock_source(clock_source), .cpu_run(cpu_run), .sys_clk_tick(sys_clk_tick),
    .clock_out_pin_oe(clock_out_pin_oe), .crystal_in_used(crystal_in_used),
    .timer_osc_enable(timer_osc_enable), .timer_ext_clock_select(timer_ext_clock_select),
    .rc_trim_value(rc_trim_value));
`default_nettype wire

// >>> csp_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
module csp_osc_model #(
    parameter int TICK_DIV = 2
) (
    input  wire logic ref_clk,
    output logic      wdt_osc_tick
);
    logic [7:0] cnt_q = 8'h00;
    // The oscillator keeps one fixed period and never jumps in frequency.
    always @(posedge ref_clk) begin
        cnt_q <= (cnt_q >= 8'(TICK_DIV - 1)) ? 8'h00 : cnt_q + 8'h01;
    end
    assign wdt_osc_tick = (cnt_q == 8'h00);
endmodule
`default_nettype wire

// >>> csp_clock_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module csp_clock_ctrl_tb;
    logic        ref_clk, rst_n, clock_out_fuse, divide_by_eight_fuse, wdt_osc_tick, sleep_req, wake_req;
    logic        avs_read, avs_write, avs_waitrequest, cpu_run, sys_clk_tick, clock_out_pin_o, clock_out_pin_oe;
    logic        crystal_in_used, timer_osc_enable, timer_ext_clock_select;
    logic [3:0]  clock_source_fuses, avs_address, avs_byteenable;
    logic [1:0]  startup_time_fuses, clock_source;
    logic [7:0]  calib_byte, rc_trim_value;
    logic [31:0] avs_writedata, avs_readdata, rd;
    int          mismatches, comparisons, n, p;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    csp_osc_model #(.TICK_DIV(2)) csp_osc_model_i (.ref_clk(ref_clk), .wdt_osc_tick(wdt_osc_tick));
    csp_clock_ctrl #(.WAKE_32K_CK(17'h00028), .WDT_64K_CYC(17'h0001E)) csp_clock_ctrl_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .clock_source_fuses(clock_source_fuses),
        .startup_time_fuses(startup_time_fuses), .clock_out_fuse(clock_out_fuse),
        .divide_by_eight_fuse(divide_by_eight_fuse), .calib_byte(calib_byte), .wdt_osc_tick(wdt_osc_tick),
        .sleep_req(sleep_req), .wake_req(wake_req), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .clock_source(clock_source),
        .cpu_run(cpu_run), .sys_clk_tick(sys_clk_tick), .clock_out_pin_o(clock_out_pin_o),
        .clock_out_pin_oe(clock_out_pin_oe), .crystal_in_used(crystal_in_used),
        .timer_osc_enable(timer_osc_enable), .timer_ext_clock_select(timer_ext_clock_select),
        .rc_trim_value(rc_trim_value));

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got %h expected %h", $time, g, e);
        end
    endtask

    // Holds the request until waitrequest is sampled low at a rising edge; read data are taken there.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge ref_clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rd, e);
    endtask

    task automatic count_until(input logic [7:0] mode);
        n = 1;
        @(negedge ref_clk);
        while ((mode == 8'h00 ? cpu_run : sys_clk_tick) !== 1'b1 && n < 20000) begin
            n++;
            @(negedge ref_clk);
        end
    endtask

    task automatic period;
        count_until(8'h01);
        count_until(8'h01);
        p = n;
    endtask

    task automatic cfg(input logic [3:0] s, input logic [1:0] u, input logic d8, input logic co);
        @(posedge ref_clk);
        clock_source_fuses <= s;
        startup_time_fuses <= u;
        divide_by_eight_fuse <= d8;
        clock_out_fuse <= co;
        rst_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        count_until(8'h00);
    endtask

    task automatic in_range(input int lo);
        chk(32'(n >= lo && n <= lo + 6), 32'h1);
    endtask

    task automatic wake(input int lo);
        @(posedge ref_clk);
        sleep_req <= 1'b1;
        @(posedge ref_clk);
        sleep_req <= 1'b0;
        repeat (3) @(posedge ref_clk);
        chk(cpu_run, 1'b0);
        wake_req <= 1'b1;
        @(posedge ref_clk);
        wake_req <= 1'b0;
        count_until(8'h00);
        in_range(lo);
    endtask

    initial begin
        {rst_n, sleep_req, wake_req, avs_read, avs_write} = '0;
        {clock_source_fuses, startup_time_fuses, clock_out_fuse, divide_by_eight_fuse} = '0;
        {avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        calib_byte = 8'h5A;
        cfg(4'h2, 2'h0, 1'b1, 1'b1);
        in_range(14);
        chk(clock_source, 2'h1);
        chk({timer_osc_enable, crystal_in_used, clock_out_pin_oe}, 3'h5);
        rd_chk(4'h0, 32'h5A);
        rd_chk(4'h4, 32'h3);
        period;
        chk(p, 8);
        n = 0;
        repeat (8) begin
            @(negedge ref_clk);
            n += (clock_out_pin_o === 1'b1);
        end
        chk(n, 4);
        bus(1'b1, 4'h0, 32'h33);
        chk(rc_trim_value, 32'h33);
        rd_chk(4'h0, 32'h33);
        rd_chk(4'h2, 32'h0);
        bus(1'b1, 4'h4, 32'h2);
        rd_chk(4'h4, 32'h3);
        bus(1'b1, 4'h4, 32'h80);
        repeat (6) @(posedge ref_clk);
        bus(1'b1, 4'h4, 32'h1);
        rd_chk(4'h4, 32'h3);
        for (int k = 0; k < 10; k++) begin
            bus(1'b1, 4'h4, 32'h80);
            bus(1'b1, 4'h4, 32'(k));
            rd_chk(4'h4, (k > 8) ? 32'h8 : 32'(k));
            period;
            chk(p, 1 << ((k > 8) ? 8 : k));
        end
        bus(1'b1, 4'h8, 32'h1);
        chk(timer_ext_clock_select, 1'b1);
        wake(6);
        cfg(4'h7, 2'h1, 1'b0, 1'b0);
        in_range(14 + 8192);
        chk({clock_source, timer_osc_enable, clock_out_pin_oe}, 4'h8);
        rd_chk(4'h4, 32'h0);
        wake(40);
        cfg(4'h6, 2'h0, 1'b0, 1'b0);
        wake(1024);
        cfg(4'h0, 2'h2, 1'b0, 1'b1);
        in_range(14 + 60);
        chk(clock_source, 2'h0);
        wake(6);
        rd_chk(4'hC, 32'h1000);
        close_out;
    end

    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        close_out;
    end
endmodule
`default_nettype wire
